// ==== rtl/ivs_pkg.sv ====
package ivs_pkg;
  localparam int          ADDR_W          = 24;
  localparam int          VEC_W           = 8;
  localparam int          PRIO_W          = 3;
  localparam int          BOOT_LIMIT_W    = 13;
  localparam int          NUM_IRQ         = 48;
  // vector table entries are two address units apart
  localparam logic [23:0] TABLE_BASE      = 24'h000004;
  localparam logic [23:0] IRQ_TABLE_BASE  = 24'h000014;
  localparam logic [7:0]  IRQ_VEC_OFFSET  = 8'h08;
  localparam logic [23:0] RESET_ADDR      = 24'h000000;
  localparam logic [7:0]  MATH_VEC        = 8'h04;
  localparam logic [23:0] MATH_TABLE_ADDR = 24'h00000c;
  localparam logic [3:0]  MATH_PRIO       = 4'hb;
  localparam int          ALT_EN_BIT      = 8;
  // positions in interrupt_control_one
  localparam int          MATH_FLAG_BIT   = 4;
  localparam int          OVA_TYPE_BIT    = 14;
  localparam int          OVB_TYPE_BIT    = 13;
  localparam int          COVA_TYPE_BIT   = 12;
  localparam int          COVB_TYPE_BIT   = 11;
  localparam int          SFT_TYPE_BIT    = 7;
  localparam int          DIV0_TYPE_BIT   = 6;
  localparam int          OVA_EN_BIT      = 10;
  localparam int          OVB_EN_BIT      = 9;
  localparam int          COMMON_EN_BIT   = 8;
  localparam logic [12:0] MIN_BOOT_PAGES  = 13'h0002;
  localparam logic [23:0] PAGE_SIZE       = 24'h000800;
  // request numbers that have no flag, enable or priority bits
  // 5, 22, 32 to 34, 39 and 42; request 47 is a live source
  localparam logic [47:0] RESERVED_IRQS   = 48'h0487_0040_0020;
  localparam logic [15:0] CTL1_RESET      = 16'h0000;
  typedef enum logic [1:0] {
    IVS_IDLE = 2'b01,
    IVS_READ = 2'b10
  } ivs_state_t;
endpackage

// ==== rtl/ivs_table_if.sv ====
`timescale 1ns/1ps
interface ivs_table_if #(parameter int IDX_W = 9) ();
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [23:0]      wr_data;
  logic             rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [23:0]      rd_data;
  modport ctl (output wr_en, output wr_idx, output wr_data, output rd_en, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_en, input rd_idx, output rd_data);
endinterface

// ==== rtl/ivs_table_mem.sv ====
`timescale 1ns/1ps
module ivs_table_mem #(
  parameter int IDX_W = 9
) (
  input wire logic    clk_sys, // system clock
  ivs_table_if.mem    tbl      // table access
);
  logic [23:0] mem_q [0:(1<<IDX_W)-1];
  logic [23:0] rd_data_reg;

  always_ff @(posedge clk_sys) begin
    if (tbl.wr_en) begin
      mem_q[tbl.wr_idx] <= tbl.wr_data;
    end
  end

  // no reset on the data path; contents are loaded by software before use
  always_ff @(posedge clk_sys) begin
    if (tbl.rd_en) begin
      rd_data_reg <= mem_q[tbl.rd_idx];
    end
  end

  assign tbl.rd_data = rd_data_reg;
endmodule

// ==== rtl/ivs_vector_select.sv ====
`timescale 1ns/1ps
// Summary of operation
// - alternate table used only with boot segment defined and alternate table switched on
// - alternate table needs config bit programmed and control-two bit 8 set
// - while enabled, every interrupt and exception fetches from the alternate table
// - alternate table base is start of last boot segment page, limit is 13 bits
// - upper half of that last page is reported unusable when alternate table on
// - alternate table refused unless boot segment spans at least two pages
// - boot segment code protection covers both default and alternate tables
// - reset is handled without the interrupt controller, never vectored
// - reset clears registers, fetch address zero, execution starts at 0x000000
// - six math causes go to vector 4 at 0x00000C, priority 11, own type flags
// - accumulator A/B overflow enables bits 10 and 9, others share bit 8
// - request n uses vector n+8 at 0x14+2n with flag, enable, priority positions
// - reserved request numbers have no bits; later sources keep fixed positions
// - all peripheral requests combine into one request line to the core
// - equal priority ties go to the lower vector number
// - each table entry is a 24-bit handler address loaded as next fetch address
// - seven user priority levels selected through 3-bit fields
module ivs_vector_select #(
  parameter int NUM_IRQ = ivs_pkg::NUM_IRQ,
  parameter int IDX_W   = 9
) (
  input  wire logic                  clk_sys,          // system clock, 10 MHz
  input  wire logic                  reset_n,          // async reset, active low
  input  wire logic [NUM_IRQ-1:0]    irq_event,        // source request pulses
  input  wire logic [NUM_IRQ-1:0]    flag_clear,       // software flag clear pulses
  input  wire logic [NUM_IRQ-1:0]    request_enable,   // enable words, bit n mod 16 of word n/16
  input  wire logic [4*NUM_IRQ-1:0]  priority_fields,  // 3-bit field at 4(n mod 4) of word n/4
  input  wire logic [5:0]            math_cause,       // ova, ovb, cova, covb, shift, div0 pulses
  input  wire logic [5:0]            math_type_clear,  // software clears for the type flags
  input  wire logic                  math_flag_clear,  // software clear of the math trap flag
  input  wire logic [15:0]           interrupt_control_two, // runtime control word
  input  wire logic [15:0]           ctl1_enables,     // math enable image of control one
  input  wire logic [3:0]            core_priority,    // current core priority level
  input  wire logic                  core_ack,         // core takes the offered vector
  input  wire logic                  alt_table_config_disable, // nonvolatile bit, 0 when programmed
  input  wire logic                  boot_segment_defined, // boot segment configured
  input  wire logic [12:0]           boot_segment_limit,   // boot segment size in pages
  input  wire logic                  boot_protect,     // boot segment write protection
  input  wire logic                  tbl_wr_en,        // table write strobe
  input  wire logic                  tbl_wr_alt,       // write to alternate table
  input  wire logic [7:0]            tbl_wr_vec,       // vector number to write
  input  wire logic [23:0]           tbl_wr_data,      // handler address
  output      logic                  core_irq,         // single request to the core
  output      logic [7:0]            vector_num,       // offered vector number
  output      logic [23:0]           vector_addr,      // offered table address
  output      logic [3:0]            vector_prio,      // offered priority
  output      logic                  handler_valid,    // pulse, next_fetch_addr updated
  output      logic [23:0]           next_fetch_addr,  // program fetch address
  output      logic [NUM_IRQ-1:0]    request_flags,    // flag words
  output      logic [15:0]           interrupt_control_one, // math flags image
  output      logic                  alt_active,       // alternate table in use
  output      logic [23:0]           alt_table_base,   // alternate table base
  output      logic [23:0]           reserved_lo,      // first unusable address
  output      logic [23:0]           reserved_hi,      // last unusable address
  output      logic                  reserved_valid,   // reserved range applies
  output      logic                  tbl_wr_refused    // table write blocked by protection
);
  ivs_table_if #(.IDX_W(IDX_W)) tbl ();
  ivs_table_mem #(.IDX_W(IDX_W)) u_mem (.clk_sys(clk_sys), .tbl(tbl));

  function automatic logic [23:0] table_addr(input logic [7:0] vec);
    table_addr = ivs_pkg::TABLE_BASE + {15'h0000, vec, 1'b0};
  endfunction

  function automatic logic [2:0] prio_of(input logic [4*NUM_IRQ-1:0] f, input int n);
    prio_of = f[4*n +: 3];
  endfunction

  ivs_pkg::ivs_state_t state_reg;
  logic [NUM_IRQ-1:0] flag_reg;
  logic [5:0]       type_reg;
  logic             math_reg;
  logic             alt_reg;
  logic [23:0]      base_reg;
  logic [7:0]       vec_reg;
  logic [23:0]      vaddr_reg;
  logic [3:0]       vprio_reg;
  logic             irq_reg;
  logic [23:0]      fetch_reg;
  logic             valid_reg;
  logic             refused_reg;
  logic             alt_next;
  logic [23:0]      base_next;
  logic [2:0]       best_prio;
  logic [7:0]       best_vec;
  logic             math_pend;
  logic [5:0]       math_en;
  logic [3:0]       win_prio;
  logic [7:0]       win_vec;
  logic             win_req;
  logic [NUM_IRQ-1:0] real_irq;

  assign real_irq = ~ivs_pkg::RESERVED_IRQS[NUM_IRQ-1:0];

  // alternate table qualification
  always_comb begin
    alt_next = boot_segment_defined && !alt_table_config_disable
      && interrupt_control_two[ivs_pkg::ALT_EN_BIT]
      && (boot_segment_limit >= ivs_pkg::MIN_BOOT_PAGES);
    base_next = 24'({11'h000, boot_segment_limit} - 24'h000001) * ivs_pkg::PAGE_SIZE;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alt_reg  <= 1'b0;
      base_reg <= 24'h000000;
    end else begin
      alt_reg  <= alt_next;
      base_reg <= base_next;
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= ((flag_reg & ~flag_clear) | irq_event) & real_irq;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      type_reg <= 6'h00;
      math_reg <= 1'b0;
    end else begin
      type_reg <= (type_reg & ~math_type_clear) | math_cause;
      math_reg <= (math_reg & ~math_flag_clear) | (|(math_cause & math_en));
    end
  end

  always_comb begin
    math_en = {ctl1_enables[ivs_pkg::OVA_EN_BIT], ctl1_enables[ivs_pkg::OVB_EN_BIT],
               {4{ctl1_enables[ivs_pkg::COMMON_EN_BIT]}}};
    math_pend = math_reg;
  end

  // descending scan with >= lets the lowest request number win ties
  always_comb begin
    best_prio = 3'h0;
    best_vec  = 8'h00;
    for (int n = NUM_IRQ - 1; n >= 0; n--) begin
      if (flag_reg[n] && request_enable[n] && real_irq[n] && prio_of(priority_fields, n) != 3'h0
          && prio_of(priority_fields, n) >= best_prio) begin
        best_prio = prio_of(priority_fields, n);
        best_vec  = 8'(n) + ivs_pkg::IRQ_VEC_OFFSET;
      end
    end
  end

  // math trap outranks every user level
  always_comb begin
    if (math_pend) begin
      win_prio = ivs_pkg::MATH_PRIO;
      win_vec  = ivs_pkg::MATH_VEC;
      win_req  = 1'b1;
    end else begin
      win_prio = {1'b0, best_prio};
      win_vec  = best_vec;
      win_req  = (best_prio != 3'h0) && ({1'b0, best_prio} > core_priority);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg   <= 1'b0;
      vec_reg   <= 8'h00;
      vaddr_reg <= 24'h000000;
      vprio_reg <= 4'h0;
    end else begin
      // withdrawn while a fetch is in flight so one ack maps to one vector
      irq_reg   <= win_req && (state_reg == ivs_pkg::IVS_IDLE) && !(core_ack && irq_reg);
      vec_reg   <= win_vec;
      vaddr_reg <= alt_next ? base_next + table_addr(win_vec) : table_addr(win_vec);
      vprio_reg <= win_prio;
    end
  end

  // vector fetch sequence
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ivs_pkg::IVS_IDLE;
    end else begin
      unique case (state_reg)
        ivs_pkg::IVS_IDLE: begin
          if (core_ack && irq_reg) begin
            state_reg <= ivs_pkg::IVS_READ;
          end
        end
        ivs_pkg::IVS_READ: begin
          state_reg <= ivs_pkg::IVS_IDLE;
        end
      endcase
    end
  end

  // fetch address starts at zero and follows each taken vector
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fetch_reg <= ivs_pkg::RESET_ADDR;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= (state_reg == ivs_pkg::IVS_READ);
      if (state_reg == ivs_pkg::IVS_READ) begin
        fetch_reg <= tbl.rd_data;
      end
    end
  end

  // both tables sit in the protected boot segment
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= tbl_wr_en && boot_protect;
    end
  end

  assign tbl.wr_en   = tbl_wr_en && !boot_protect;
  assign tbl.wr_idx  = IDX_W'({tbl_wr_alt, tbl_wr_vec});
  assign tbl.wr_data = tbl_wr_data;
  assign tbl.rd_en   = core_ack && irq_reg && (state_reg == ivs_pkg::IVS_IDLE);
  assign tbl.rd_idx  = IDX_W'({alt_reg, vec_reg});

  always_comb begin
    interrupt_control_one = ivs_pkg::CTL1_RESET;
    interrupt_control_one[ivs_pkg::MATH_FLAG_BIT] = math_reg;
    interrupt_control_one[ivs_pkg::OVA_TYPE_BIT]  = type_reg[5];
    interrupt_control_one[ivs_pkg::OVB_TYPE_BIT]  = type_reg[4];
    interrupt_control_one[ivs_pkg::COVA_TYPE_BIT] = type_reg[3];
    interrupt_control_one[ivs_pkg::COVB_TYPE_BIT] = type_reg[2];
    interrupt_control_one[ivs_pkg::SFT_TYPE_BIT]  = type_reg[1];
    interrupt_control_one[ivs_pkg::DIV0_TYPE_BIT] = type_reg[0];
  end

  assign core_irq        = irq_reg;
  assign vector_num      = vec_reg;
  assign vector_addr     = vaddr_reg;
  assign vector_prio     = vprio_reg;
  assign handler_valid   = valid_reg;
  assign next_fetch_addr = fetch_reg;
  assign request_flags   = flag_reg;
  assign alt_active      = alt_reg;
  assign alt_table_base  = base_reg;
  assign reserved_lo     = base_reg + (ivs_pkg::PAGE_SIZE >> 1);
  assign reserved_hi     = base_reg + ivs_pkg::PAGE_SIZE - 24'h000001;
  assign reserved_valid  = alt_reg;
  assign tbl_wr_refused  = refused_reg;
endmodule

// ==== bench/ivs_vector_select_monitor.sv ====
`timescale 1ns/1ps
module ivs_vector_select_monitor #(
  parameter int NUM_IRQ = 48
) (
  input wire logic               clk_sys,                  // clock
  input wire logic               reset_n,                  // reset
  input wire logic [NUM_IRQ-1:0] flag_clear,               // clears
  input wire logic [15:0]        interrupt_control_two,    // control
  input wire logic               core_ack,                 // take
  input wire logic               alt_table_config_disable, // config
  input wire logic               boot_segment_defined,     // defined
  input wire logic [12:0]        boot_segment_limit,       // pages
  input wire logic               core_irq,                 // request
  input wire logic [7:0]         vector_num,               // vector
  input wire logic [23:0]        vector_addr,              // address
  input wire logic [3:0]         vector_prio,              // priority
  input wire logic               handler_valid,            // strobe
  input wire logic [NUM_IRQ-1:0] request_flags,            // flags
  input wire logic               alt_active,               // alt on
  input wire logic [23:0]        alt_table_base,           // base
  input wire logic [23:0]        reserved_lo,              // low
  input wire logic [23:0]        reserved_hi,              // high
  input wire logic               reserved_valid            // applies
);
  logic alt_cond;
  assign alt_cond = !alt_table_config_disable && interrupt_control_two[8] && boot_segment_defined
                    && boot_segment_limit >= 13'h0002;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_alt_on; alt_cond |=> alt_active; endproperty
  a_alt_on: assert property (p_alt_on) else $error("alt table not entered");
  property p_alt_off; !boot_segment_defined || boot_segment_limit < 13'h0002 |=> !alt_active; endproperty
  a_alt_off: assert property (p_alt_off) else $error("alt table without two boot pages");
  property p_base; alt_active && $stable(boot_segment_limit)
    |-> alt_table_base == ({11'h000, boot_segment_limit} - 24'h1) * 24'h800; endproperty
  a_base: assert property (p_base) else $error("alt base not at last page");
  property p_rsv; reserved_valid == alt_active && reserved_lo == alt_table_base + 24'h400
    && reserved_hi == alt_table_base + 24'h7ff; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved half page wrong");
  property p_handler; core_irq && core_ack |-> ##2 handler_valid; endproperty
  a_handler: assert property (p_handler) else $error("handler not loaded two cycles after take");
  property p_quiet; core_irq && core_ack |=> !core_irq [*2]; endproperty
  a_quiet: assert property (p_quiet) else $error("request not dropped after take");
  property p_addr; core_irq && $stable(alt_active) |-> vector_addr == 24'h4 + {15'h0, vector_num, 1'b0}
    + (alt_active ? alt_table_base : 24'h0); endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_prio; core_irq && vector_num == 8'h04 |-> vector_prio == 4'hb; endproperty
  a_prio: assert property (p_prio) else $error("math trap priority wrong");
  property p_hold; ##1 (request_flags & $past(request_flags & ~flag_clear))
    == $past(request_flags & ~flag_clear); endproperty
  a_hold: assert property (p_hold) else $error("pending flag lost");
endmodule
bind ivs_vector_select ivs_vector_select_monitor #(.NUM_IRQ(NUM_IRQ)) u_ivs_vector_select_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .flag_clear(flag_clear), .interrupt_control_two(interrupt_control_two),
  .core_ack(core_ack), .alt_table_config_disable(alt_table_config_disable),
  .boot_segment_defined(boot_segment_defined), .boot_segment_limit(boot_segment_limit), .core_irq(core_irq),
  .vector_num(vector_num), .vector_addr(vector_addr), .vector_prio(vector_prio), .handler_valid(handler_valid),
  .request_flags(request_flags), .alt_active(alt_active), .alt_table_base(alt_table_base),
  .reserved_lo(reserved_lo), .reserved_hi(reserved_hi), .reserved_valid(reserved_valid));

// ==== bench/ivs_core_model.sv ====
`timescale 1ns/1ps
module ivs_core_model (
  input  wire logic        clk_sys,         // clock
  input  wire logic        reset_n,         // reset
  input  wire logic        core_irq,        // request
  input  wire logic [7:0]  vector_num,      // vector
  input  wire logic        handler_valid,   // strobe
  input  wire logic [23:0] next_fetch_addr, // handler
  input  wire logic [1:0]  ack_delay,       // slowness
  output      logic        core_ack,        // take
  output      logic [7:0]  taken_vec,       // taken vector
  output      logic [23:0] taken_addr,      // fetched handler
  output      int          taken_cnt        // handlers entered
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_ack  <= 1'b0;
      wait_reg  <= 2'h0;
      taken_vec <= 8'h00;
    end else if (core_ack) begin
      // the request is still up on the taking edge
      core_ack  <= 1'b0;
      taken_vec <= vector_num;
      wait_reg  <= 2'h0;
    end else if (core_irq && wait_reg >= ack_delay) begin
      core_ack <= 1'b1;
    end else if (core_irq) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      taken_addr <= 24'h000000;
      taken_cnt  <= 0;
    end else if (handler_valid) begin
      taken_addr <= next_fetch_addr;
      taken_cnt  <= taken_cnt + 1;
    end
  end
endmodule

// ==== bench/interrupt_vector_selection_tb.sv ====
`timescale 1ns/1ps
module interrupt_vector_selection_tb;
  logic         clk_sys, reset_n, math_flag_clear, alt_table_config_disable, boot_segment_defined, boot_protect;
  logic         tbl_wr_en, tbl_wr_alt, core_irq, handler_valid, alt_active, reserved_valid, tbl_wr_refused, core_ack;
  logic [47:0]  irq_event, flag_clear, request_enable, request_flags;
  logic [191:0] priority_fields;
  logic [5:0]   math_cause, math_type_clear;
  logic [15:0]  interrupt_control_two, ctl1_enables, interrupt_control_one;
  logic [12:0]  boot_segment_limit;
  logic [7:0]   tbl_wr_vec, vector_num, taken_vec;
  logic [23:0]  tbl_wr_data, vector_addr, next_fetch_addr, alt_table_base, reserved_lo, reserved_hi, taken_addr;
  logic [3:0]   core_priority, vector_prio;
  logic [1:0]   ack_delay;
  logic [31:0]  rnd;
  int           failures, samples_checked, cycles, taken_cnt, i, n;
  ivs_vector_select u_ivs_vector_select (.*);
  ivs_core_model u_ivs_core_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [23:0] entry(input logic a, input logic [7:0] v);
    return {a ? 8'h9a : 8'h1c, v, ~v};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic [47:0] m);
    @(posedge clk_sys);
    irq_event <= m;
    @(posedge clk_sys);
    irq_event <= 48'h0;
  endtask
  // waits for the take, clears the source flag, then compares what the core fetched
  task automatic serve(input logic [7:0] v, input logic a);
    int c0;
    int t;
    c0 = taken_cnt;
    t = 0;
    while (core_ack !== 1'b1 && t < 50) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    @(posedge clk_sys);
    if (v == 8'h04) math_flag_clear <= 1'b1;
    else flag_clear[int'(v) - 8] <= 1'b1;
    @(posedge clk_sys);
    math_flag_clear <= 1'b0;
    flag_clear <= 48'h0;
    while (taken_cnt == c0 && t < 50) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    check(t < 50, 1'b1);
    check(taken_vec, v);
    check(taken_addr, entry(a, v));
  endtask
  initial begin
    reset_n = 1'b0; irq_event = 48'h0; flag_clear = 48'h0; request_enable = '1; priority_fields = 192'h0;
    math_cause = 6'h00; math_type_clear = 6'h00; math_flag_clear = 1'b0; interrupt_control_two = 16'h0000;
    ctl1_enables = 16'h0700; core_priority = 4'h0; alt_table_config_disable = 1'b1; boot_segment_defined = 1'b0;
    boot_segment_limit = 13'h0003; boot_protect = 1'b0; tbl_wr_en = 1'b0; tbl_wr_alt = 1'b0; tbl_wr_vec = 8'h00;
    tbl_wr_data = 24'h0; ack_delay = 2'h0; rnd = 32'h0000_0055; cycles = 0; failures = 0; samples_checked = 0;
    tick(20);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(next_fetch_addr, 24'h000000);
    check(request_flags, 48'h0);
    check({core_irq, handler_valid}, 2'b00);
    for (i = 0; i < 128; i++) begin
      @(posedge clk_sys);
      tbl_wr_en <= 1'b1;
      tbl_wr_alt <= i[6];
      tbl_wr_vec <= {2'b00, i[5:0]};
      tbl_wr_data <= entry(i[6], {2'b00, i[5:0]});
    end
    @(posedge clk_sys);
    tbl_wr_en <= 1'b0;
    boot_protect <= 1'b1;
    @(posedge clk_sys);
    tbl_wr_en <= 1'b1;
    tbl_wr_vec <= 8'h08;
    tbl_wr_alt <= 1'b0;
    @(posedge clk_sys);
    tbl_wr_en <= 1'b0;
    #1;
    check(tbl_wr_refused, 1'b1);
    priority_fields[2:0] <= 3'h1;
    pulse(48'h1);
    serve(8'h08, 1'b0);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      priority_fields[14:12] <= 3'h2;
      priority_fields[42:40] <= (i == 1) ? 3'h5 : 3'h2;
      pulse(48'h408);
      serve((i == 1) ? 8'h12 : 8'h0b, 1'b0);
      serve((i == 1) ? 8'h0b : 8'h12, 1'b0);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      request_enable[4] <= (i != 0);
      priority_fields[18:16] <= (i == 1) ? 3'h0 : 3'h3;
      core_priority <= (i == 2) ? 4'h3 : 4'h0;
      pulse(48'h10);
      tick(4);
      #1;
      check(core_irq, 1'b0);
      check(request_flags[4], 1'b1);
      @(posedge clk_sys);
      flag_clear <= 48'h10;
      priority_fields[18:16] <= 3'h0;
      request_enable[4] <= 1'b1;
      core_priority <= 4'h0;
      @(posedge clk_sys);
      flag_clear <= 48'h0;
    end
    @(posedge clk_sys);
    math_cause <= 6'h20;
    @(posedge clk_sys);
    math_cause <= 6'h00;
    serve(8'h04, 1'b0);
    ctl1_enables <= 16'h0000;
    math_cause <= 6'h02;
    @(posedge clk_sys);
    math_cause <= 6'h00;
    tick(2);
    #1;
    check({interrupt_control_one[7], interrupt_control_one[4], core_irq}, 3'b100);
    @(posedge clk_sys);
    math_type_clear <= 6'h3f;
    @(posedge clk_sys);
    math_type_clear <= 6'h00;
    tick(1);
    #1;
    check(interrupt_control_one, 16'h0000);
    @(posedge clk_sys);
    alt_table_config_disable <= 1'b0;
    interrupt_control_two <= 16'h0100;
    boot_segment_defined <= 1'b1;
    priority_fields[142:140] <= 3'h4;
    tick(2);
    #1;
    check({alt_active, alt_table_base, reserved_lo}, {1'b1, 24'h001000, 24'h001400});
    pulse(48'h8_0000_0000);
    serve(8'h2b, 1'b1);
    @(posedge clk_sys);
    boot_segment_limit <= 13'h0001;
    tick(2);
    #1;
    check(alt_active, 1'b0);
    for (i = 0; i < 40; i++) begin
      rnd = xs(rnd);
      n = int'(rnd % 32'd48);
      @(posedge clk_sys);
      priority_fields[4*n +: 3] <= 3'(rnd[10:8] % 7 + 1);
      ack_delay <= rnd[13:12];
      pulse(48'h1 << n);
      if (n inside {5, 22, 32, 33, 34, 39, 42}) begin
        tick(3);
        #1;
        check({request_flags, core_irq}, 49'h0);
      end else serve(8'(n + 8), 1'b0);
    end
    end_of_test();
  end
endmodule
